// ### logic/stc_pkg.sv
package stc_pkg;
    // register addresses on the plain port (all chosen here)
    localparam logic [2:0] STC_ADDR_CONTROL = 3'h0;
    localparam logic [2:0] STC_ADDR_COUNT_LOW = 3'h1;
    localparam logic [2:0] STC_ADDR_COUNT_HIGH = 3'h2;
    localparam logic [2:0] STC_ADDR_FLAG = 3'h3;
    localparam logic [2:0] STC_ADDR_ENABLE = 3'h4;

    // timer_control field positions
    localparam int STC_BIT_COUNTER_ON = 0;
    localparam int STC_BIT_CLOCK_SOURCE = 1;
    localparam int STC_BIT_EXT_SYNC = 2;
    localparam int STC_BIT_OSC_ENABLE = 3;
    localparam int STC_BIT_PRESCALE_LO = 4;
    localparam int STC_BIT_PRESCALE_HI = 5;
    localparam int STC_BIT_UNUSED = 6;
    localparam int STC_BIT_WIDE_ACCESS = 7;
    localparam logic [7:0] STC_CONTROL_WMASK = 8'hBF;

    // reset values and the count maximum
    localparam logic [7:0] STC_CONTROL_RESET = 8'h00;
    localparam logic [15:0] STC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] STC_COUNT_MAX = 16'hFFFF;

    // compare unit mode that resets the count
    localparam logic [3:0] STC_MODE_SPECIAL_TRIGGER = 4'hB;

    // instruction cycle is four system clocks
    localparam logic [1:0] STC_PHASE_LAST = 2'h3;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } stc_bus_s;

    typedef struct packed {
        logic [7:0] control;
        logic [15:0] count;
        logic [7:0] high_buffer;
        logic [2:0] prescale_count;
        logic [1:0] phase;
        logic [1:0] ext_sync;
        logic [1:0] osc_sync;
        logic ext_prev;
        logic ext_pending;
        logic overflow_flag;
        logic overflow_irq_enable;
        logic [7:0] rdata;
        logic irq;
        logic conversion_start;
        logic osc_run;
        logic [1:0] pin_oe;
        logic [1:0] pin_read;
        logic [3:0] pin_sync;
    } stc_state_s;
endpackage

// ### logic/stc_timer.sv
// What this block does
// - count only while counter_on is set
// - wide_access_mode picks buffered sixteen-bit access
// - prescale_select divides by one, two, four, eight
// - osc_enable switches dedicated oscillator on or off
// - ext_sync_select chooses aligned or raw external edges
// - source select: instruction cycle or external rising edge
// - oscillator on forces pins input, read zero
// - oscillator keeps running during sleep
// - wrap FFFFh to 0000h sets overflow flag
// - interrupt request only while enable bit set
// - special trigger resets count, starts conversion
// - trigger reset never sets overflow flag
// - trigger reset honoured only in synchronous modes
// - software count write beats simultaneous trigger
// - compare value acts as the period
// - wide low read copies high byte into buffer
// - wide low write loads high from buffer
// - in wide mode, live high byte reached only through buffer
// - low write clears prescaler, high write not
// - control bit six reads zero, ignores writes
`timescale 1ns/10ps
module stc_timer (
    input wire logic clock,
    input wire logic reset_n,
    input wire stc_pkg::stc_bus_s bus,
    output logic [7:0] rdata,
    input wire logic ext_clock_pin,
    input wire logic osc_in_pin,
    input wire logic sleep_mode,
    input wire logic [1:0] port_direction,
    input wire logic [1:0] pin_level,
    input wire logic special_trigger,
    input wire logic [3:0] compare_mode_field,
    input wire logic converter_enabled,
    output logic [1:0] pin_oe,
    output logic [1:0] pin_read,
    output logic osc_run,
    output logic irq,
    output logic conversion_start
);
    import stc_pkg::*;

    stc_state_s state_reg;
    stc_state_s state_next;

    logic wide;
    logic on;
    logic ext_mode;
    logic raw_mode;
    logic phase_end;
    logic ext_edge;
    logic src_tick;
    logic [2:0] limit;
    logic count_tick;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic trig_reset;

    always_comb begin
        wide = state_reg.control[STC_BIT_WIDE_ACCESS];
        on = state_reg.control[STC_BIT_COUNTER_ON];
        ext_mode = state_reg.control[STC_BIT_CLOCK_SOURCE];
        raw_mode = ext_mode && state_reg.control[STC_BIT_EXT_SYNC];
        // the processor runs no instruction cycles while asleep
        phase_end = (state_reg.phase == STC_PHASE_LAST) && !sleep_mode;
        // the oscillator, once on, replaces the pin as the edge source
        if (state_reg.control[STC_BIT_OSC_ENABLE]) begin
            ext_edge = state_reg.osc_sync[1] && !state_reg.ext_prev;
        end else begin
            ext_edge = state_reg.ext_sync[1] && !state_reg.ext_prev;
        end
        if (!ext_mode) begin
            src_tick = phase_end;
        end else if (raw_mode) begin
            src_tick = ext_edge;
        end else begin
            src_tick = (state_reg.ext_pending || ext_edge) && (state_reg.phase == STC_PHASE_LAST);
        end
        case (state_reg.control[STC_BIT_PRESCALE_HI:STC_BIT_PRESCALE_LO])
            2'h0: limit = 3'h0;
            2'h1: limit = 3'h1;
            2'h2: limit = 3'h3;
            2'h3: limit = 3'h7;
            default: limit = 3'h0;
        endcase
        count_tick = on && src_tick && (state_reg.prescale_count == limit);
        wr_low = bus.wr && (bus.addr == STC_ADDR_COUNT_LOW);
        wr_high = bus.wr && (bus.addr == STC_ADDR_COUNT_HIGH);
        rd_low = bus.rd && (bus.addr == STC_ADDR_COUNT_LOW);
        // a raw asynchronous count cannot be reset safely, so it is refused
        trig_reset = special_trigger && (compare_mode_field == STC_MODE_SPECIAL_TRIGGER)
            && !raw_mode;
    end

    always_comb begin
        state_next = state_reg;
        state_next.phase = state_reg.phase + 2'h1;
        state_next.ext_sync = {state_reg.ext_sync[0], ext_clock_pin};
        state_next.osc_sync = {state_reg.osc_sync[0], osc_in_pin};
        state_next.ext_prev = state_reg.control[STC_BIT_OSC_ENABLE] ? state_reg.osc_sync[1]
            : state_reg.ext_sync[1];
        if (state_reg.phase == STC_PHASE_LAST) begin
            state_next.ext_pending = 1'b0;
        end else if (ext_edge) begin
            state_next.ext_pending = 1'b1;
        end

        if (on && src_tick) begin
            if (state_reg.prescale_count == limit) begin
                state_next.prescale_count = 3'h0;
            end else begin
                state_next.prescale_count = state_reg.prescale_count + 3'h1;
            end
        end

        // order gives priority: software write, then trigger, then count
        if (trig_reset) begin
            state_next.count = STC_COUNT_RESET;
        end else if (count_tick) begin
            state_next.count = state_reg.count + 16'h0001;
        end

        if (count_tick && !trig_reset && (state_reg.count == STC_COUNT_MAX)) begin
            state_next.overflow_flag = 1'b1;
        end else if (bus.wr && (bus.addr == STC_ADDR_FLAG) && !bus.wdata[0]) begin
            state_next.overflow_flag = 1'b0;
        end

        if (wr_low) begin
            state_next.prescale_count = 3'h0;
            if (wide) begin
                state_next.count = {state_reg.high_buffer, bus.wdata};
            end else begin
                state_next.count = {state_reg.count[15:8], bus.wdata};
            end
        end
        if (wr_high) begin
            if (wide) begin
                state_next.high_buffer = bus.wdata;
            end else begin
                state_next.count = {bus.wdata, state_reg.count[7:0]};
            end
        end
        if (bus.wr && (bus.addr == STC_ADDR_CONTROL)) begin
            state_next.control = bus.wdata & STC_CONTROL_WMASK;
        end
        if (bus.wr && (bus.addr == STC_ADDR_ENABLE)) begin
            state_next.overflow_irq_enable = bus.wdata[0];
        end
        if (rd_low && wide) begin
            state_next.high_buffer = state_reg.count[15:8];
        end

        state_next.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                STC_ADDR_CONTROL: state_next.rdata = state_reg.control;
                STC_ADDR_COUNT_LOW: state_next.rdata = state_reg.count[7:0];
                STC_ADDR_COUNT_HIGH: state_next.rdata = wide ? state_reg.high_buffer
                    : state_reg.count[15:8];
                STC_ADDR_FLAG: state_next.rdata = {7'h00, state_reg.overflow_flag};
                STC_ADDR_ENABLE: state_next.rdata = {7'h00, state_reg.overflow_irq_enable};
                default: state_next.rdata = 8'h00;
            endcase
        end

        state_next.irq = state_reg.overflow_flag && state_reg.overflow_irq_enable;
        state_next.conversion_start = trig_reset && converter_enabled;
        // sleep does not touch the enable, so the crystal keeps swinging
        state_next.osc_run = state_reg.control[STC_BIT_OSC_ENABLE];
        if (state_reg.control[STC_BIT_OSC_ENABLE]) begin
            state_next.pin_oe = 2'h0;
            state_next.pin_read = 2'h0;
        end else begin
            state_next.pin_oe = ~port_direction;
            // pin levels come from outside the clock domain: two flops first
            state_next.pin_read = state_reg.pin_sync[3:2];
        end
        state_next.pin_sync = {state_reg.pin_sync[1:0], pin_level};
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.control <= STC_CONTROL_RESET;
            state_reg.count <= STC_COUNT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign pin_oe = state_reg.pin_oe;
    assign pin_read = state_reg.pin_read;
    assign osc_run = state_reg.osc_run;
    assign irq = state_reg.irq;
    assign conversion_start = state_reg.conversion_start;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    control_bit6_a: assert property (state_reg.control[STC_BIT_UNUSED] == 1'b0)
        else $error("control bit six became set");
    count_hold_a: assert property (!on && !wr_low && !wr_high && !trig_reset
        |=> $stable(state_reg.count))
        else $error("count moved while stopped");
    overflow_set_a: assert property (count_tick && !trig_reset && !wr_low && !wr_high
        && state_reg.count == STC_COUNT_MAX |=> state_reg.overflow_flag && state_reg.count == 16'h0000)
        else $error("wrap did not set the flag");
    trigger_flag_a: assert property (trig_reset && !wr_low && !wr_high && !state_reg.overflow_flag
        |=> state_reg.count == 16'h0000 && !state_reg.overflow_flag)
        else $error("trigger reset misbehaved");
    write_wins_a: assert property (trig_reset && wr_low && !wide
        |=> state_reg.count[7:0] == $past(bus.wdata))
        else $error("trigger overrode a write");
    buffer_load_a: assert property (rd_low && wide && !wr_high
        |=> state_reg.high_buffer == $past(state_reg.count[15:8]))
        else $error("low read did not load buffer");
    wide_write_a: assert property (wr_low && wide
        |=> state_reg.count == {$past(state_reg.high_buffer), $past(bus.wdata)})
        else $error("wide write not atomic");
    presc_clear_a: assert property (wr_low |=> state_reg.prescale_count == 3'h0)
        else $error("prescaler survived a low write");
    pin_input_a: assert property (state_reg.control[STC_BIT_OSC_ENABLE]
        |=> pin_oe == 2'h0 ##0 pin_read == 2'h0)
        else $error("pins driven while oscillator on");
    irq_gate_a: assert property (!state_reg.overflow_irq_enable |=> !irq)
        else $error("request passed while disabled");
    read_idle_a: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("read data outside the read slot");

    // read path: the addressed register shows up one cycle after the strobe
    low_read_a: assert property (bus.rd && bus.addr == STC_ADDR_COUNT_LOW
        |=> rdata == $past(state_reg.count[7:0]))
        else $error("low byte read wrong");
    buffer_read_a: assert property (bus.rd && bus.addr == STC_ADDR_COUNT_HIGH && wide
        |=> rdata == $past(state_reg.high_buffer))
        else $error("wide high read bypassed buffer");
    direct_high_read_a: assert property (bus.rd && bus.addr == STC_ADDR_COUNT_HIGH && !wide
        |=> rdata == $past(state_reg.count[15:8]))
        else $error("plain high read wrong");
    control_read_a: assert property (bus.rd && bus.addr == STC_ADDR_CONTROL
        |=> rdata == $past(state_reg.control))
        else $error("control read wrong");
    unmapped_read_a: assert property (bus.rd && bus.addr > STC_ADDR_ENABLE
        |=> rdata == 8'h00)
        else $error("unmapped address returned data");

    // write path: each address touches only what it owns
    control_write_a: assert property (bus.wr && bus.addr == STC_ADDR_CONTROL
        |=> state_reg.control == ($past(bus.wdata) & STC_CONTROL_WMASK))
        else $error("control write wrong");
    enable_write_a: assert property (bus.wr && bus.addr == STC_ADDR_ENABLE
        |=> state_reg.overflow_irq_enable == $past(bus.wdata[0]))
        else $error("enable write wrong");
    direct_low_write_a: assert property (wr_low && !wide
        |=> state_reg.count == {$past(state_reg.count[15:8]), $past(bus.wdata)})
        else $error("plain low write wrong");
    direct_high_write_a: assert property (wr_high && !wide
        |=> state_reg.count == {$past(bus.wdata), $past(state_reg.count[7:0])})
        else $error("plain high write wrong");
    buffer_write_a: assert property (wr_high && wide
        |=> state_reg.high_buffer == $past(bus.wdata))
        else $error("buffer write lost");
    buffer_only_a: assert property (wr_high && wide && !count_tick && !trig_reset
        |=> $stable(state_reg.count))
        else $error("wide high write reached the count");
    presc_keep_a: assert property (wr_high && !(on && src_tick)
        |=> $stable(state_reg.prescale_count))
        else $error("high write touched the prescaler");

    // counting: the prescaler gates the source ticks
    count_step_a: assert property (count_tick && !trig_reset && !wr_low && !wr_high
        |=> state_reg.count == $past(state_reg.count) + 16'h0001)
        else $error("count did not step by one");
    presc_wrap_a: assert property (count_tick && !wr_low
        |=> state_reg.prescale_count == 3'h0)
        else $error("prescaler did not restart");
    presc_step_a: assert property (on && src_tick && state_reg.prescale_count != limit && !wr_low
        |=> state_reg.prescale_count == $past(state_reg.prescale_count) + 3'h1)
        else $error("prescaler did not advance");
    stopped_presc_a: assert property (!on && !wr_low
        |=> $stable(state_reg.prescale_count))
        else $error("prescaler moved while stopped");
    timer_phase_a: assert property (!ext_mode && state_reg.phase != STC_PHASE_LAST
        |-> !count_tick)
        else $error("timer ticked off the instruction cycle");
    timer_tick_a: assert property (on && !ext_mode && phase_end && state_reg.prescale_count == limit
        |-> count_tick)
        else $error("instruction cycle tick lost");
    sync_phase_a: assert property (ext_mode && !raw_mode && state_reg.phase != STC_PHASE_LAST
        |-> !count_tick)
        else $error("synchronised count off the cycle");
    sync_pending_a: assert property (on && ext_mode && !raw_mode && state_reg.ext_pending
        && state_reg.phase == STC_PHASE_LAST && state_reg.prescale_count == limit |-> count_tick)
        else $error("pending edge not counted");
    edge_count_a: assert property (on && raw_mode && ext_edge && state_reg.prescale_count == limit
        |-> count_tick)
        else $error("raw edge not counted");

    // trigger, flag and request
    raw_refuse_a: assert property (raw_mode |-> !trig_reset)
        else $error("trigger honoured in raw mode");
    conv_pulse_a: assert property (trig_reset && converter_enabled |=> conversion_start)
        else $error("conversion start missing");
    conv_quiet_a: assert property (!trig_reset |=> !conversion_start)
        else $error("conversion start without trigger");
    flag_sticky_a: assert property (state_reg.overflow_flag && !(bus.wr && bus.addr == STC_ADDR_FLAG)
        |=> state_reg.overflow_flag)
        else $error("flag dropped on its own");
    flag_clear_a: assert property (bus.wr && bus.addr == STC_ADDR_FLAG && !bus.wdata[0]
        && !(count_tick && state_reg.count == STC_COUNT_MAX) |=> !state_reg.overflow_flag)
        else $error("flag clear ignored");
    irq_follow_a: assert property (state_reg.overflow_flag && state_reg.overflow_irq_enable
        |=> irq)
        else $error("enabled request missing");

    // oscillator and its pins
    osc_on_a: assert property (state_reg.control[STC_BIT_OSC_ENABLE] |=> osc_run)
        else $error("oscillator not running");
    osc_off_a: assert property (!state_reg.control[STC_BIT_OSC_ENABLE] |=> !osc_run)
        else $error("oscillator not shut off");
    sleep_keep_a: assert property (sleep_mode && state_reg.control[STC_BIT_OSC_ENABLE]
        |=> osc_run)
        else $error("oscillator stopped in sleep");
    pin_follow_a: assert property (!state_reg.control[STC_BIT_OSC_ENABLE]
        |=> pin_oe == ~$past(port_direction))
        else $error("pin direction not followed");
    pin_read_a: assert property (!state_reg.control[STC_BIT_OSC_ENABLE]
        |=> pin_read == $past(state_reg.pin_sync[3:2]))
        else $error("pin level not followed");

    overflow_seen_c: cover property (count_tick && state_reg.count == STC_COUNT_MAX);
    trigger_seen_c: cover property (trig_reset ##1 conversion_start);
    wide_read_c: cover property (rd_low && wide ##1 bus.rd && bus.addr == STC_ADDR_COUNT_HIGH);
    raw_count_c: cover property (raw_mode && count_tick);
    write_race_c: cover property (special_trigger && wr_low);
endmodule

// ### verification/stc_far_model.sv
`timescale 1ns/10ps
module stc_far_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic run,
    input wire logic use_osc,
    input wire logic fire,
    input wire logic [3:0] mode,
    output logic ext_clock_pin,
    output logic osc_in_pin,
    output logic special_trigger,
    output logic [3:0] compare_mode_field
);
    logic [2:0] div;
    logic line;
    assign special_trigger = fire;
    assign compare_mode_field = mode;
    // the unused source rests low so a switch adds no stray edge
    assign ext_clock_pin = use_osc ? 1'h0 : line;
    assign osc_in_pin = use_osc ? line : 1'h0;
    // one rising edge per 16 clocks, slow enough for the two-flop sampler
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            div <= 3'h0;
            line <= 1'h0;
        end else if (run) begin
            div <= div + 3'h1;
            if (div == 3'h7) begin
                line <= ~line;
            end
        end
    end
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps
module tb;
    import stc_pkg::*;
    logic clock, reset_n = 1'h0, sleep_mode = 1'h0, conv_en = 1'h1, run = 1'h0, use_osc = 1'h0, fire = 1'h0;
    stc_bus_s bus = '0;
    logic [7:0] rdata, got;
    logic [3:0] mode = STC_MODE_SPECIAL_TRIGGER;
    logic [3:0] cmode;
    logic [1:0] pdir = 2'h0, plev = 2'h3, pin_oe, pin_read;
    logic ext_pin, osc_pin, trig, osc_run, irq, conv;
    int conv_seen = 0, err_total = 0, total_checks = 0;

    stc_timer u_dut (.clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata), .ext_clock_pin(ext_pin),
        .osc_in_pin(osc_pin), .sleep_mode(sleep_mode), .port_direction(pdir), .pin_level(plev),
        .special_trigger(trig), .compare_mode_field(cmode), .converter_enabled(conv_en), .pin_oe(pin_oe),
        .pin_read(pin_read), .osc_run(osc_run), .irq(irq), .conversion_start(conv));
    stc_far_model u_far (.clock(clock), .reset_n(reset_n), .run(run), .use_osc(use_osc), .fire(fire),
        .mode(mode), .ext_clock_pin(ext_pin), .osc_in_pin(osc_pin), .special_trigger(trig),
        .compare_mode_field(cmode));

    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        if (conv === 1'h1) conv_seen <= conv_seen + 1;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clock);
        bus <= '0;
    endtask

    // rdata stands only in the cycle after the read edge, so it is taken just past that edge
    task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge clock);
        bus <= '0;
        #1 got = rdata;
        cmp(n, e, got);
    endtask

    // counter runs for exactly 4*m clocks, i.e. m instruction ticks whatever the phase
    task automatic run_ticks(input logic [7:0] c, input int m);
        wr(STC_ADDR_CONTROL, c);
        repeat (4 * m - 2) @(posedge clock);
        wr(STC_ADDR_CONTROL, c & 8'hFE);
    endtask

    task automatic pulse();
        @(posedge clock);
        fire <= 1'h1;
        @(posedge clock);
        fire <= 1'h0;
    endtask

    // 8 source edges, ending low, then time for the sampler to settle
    task automatic burst();
        @(posedge clock);
        run <= 1'h1;
        repeat (128) @(posedge clock);
        run <= 1'h0;
        repeat (20) @(posedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1'h1;
        rchk("control", STC_ADDR_CONTROL, STC_CONTROL_RESET);
        rchk("count low", STC_ADDR_COUNT_LOW, 8'h00);
        rchk("flag", STC_ADDR_FLAG, 8'h00);
        wr(3'h7, 8'hFF);
        rchk("unmapped", 3'h7, 8'h00);
        wr(STC_ADDR_CONTROL, 8'hFF);
        rchk("control", STC_ADDR_CONTROL, 8'hBF);
        wr(STC_ADDR_CONTROL, 8'h00);
        for (int ps = 0; ps < 4; ps++) begin
            wr(STC_ADDR_COUNT_LOW, 8'h00);
            wr(STC_ADDR_COUNT_HIGH, 8'h00);
            run_ticks(8'(ps * 16 + 1), 5 << ps);
            rchk("prescaled", STC_ADDR_COUNT_LOW, 8'h05);
        end
        repeat (40) @(posedge clock);
        rchk("stopped", STC_ADDR_COUNT_LOW, 8'h05);
        wr(STC_ADDR_COUNT_LOW, 8'h00);
        run_ticks(8'h11, 1);
        wr(STC_ADDR_COUNT_HIGH, 8'h00);
        run_ticks(8'h11, 1);
        rchk("prescaler kept", STC_ADDR_COUNT_LOW, 8'h01);
        wr(STC_ADDR_COUNT_HIGH, 8'hFF);
        wr(STC_ADDR_COUNT_LOW, 8'hFF);
        run_ticks(8'h01, 2);
        rchk("wrap low", STC_ADDR_COUNT_LOW, 8'h01);
        rchk("wrap high", STC_ADDR_COUNT_HIGH, 8'h00);
        rchk("flag", STC_ADDR_FLAG, 8'h01);
        cmp("irq masked", 8'h00, {7'h00, irq});
        wr(STC_ADDR_ENABLE, 8'h01);
        repeat (2) @(posedge clock);
        cmp("irq", 8'h01, {7'h00, irq});
        wr(STC_ADDR_FLAG, 8'h00);
        repeat (2) @(posedge clock);
        cmp("irq cleared", 8'h00, {7'h00, irq});
        wr(STC_ADDR_COUNT_HIGH, 8'h12);
        wr(STC_ADDR_COUNT_LOW, 8'h34);
        pulse();
        rchk("trig low", STC_ADDR_COUNT_LOW, 8'h00);
        rchk("trig high", STC_ADDR_COUNT_HIGH, 8'h00);
        rchk("trig flag", STC_ADDR_FLAG, 8'h00);
        cmp("conversions", 8'h01, 8'(conv_seen));
        wr(STC_ADDR_COUNT_LOW, 8'h34);
        mode <= 4'hA;
        pulse();
        rchk("other mode", STC_ADDR_COUNT_LOW, 8'h34);
        @(posedge clock);
        mode <= STC_MODE_SPECIAL_TRIGGER;
        fire <= 1'h1;
        bus <= '{addr: STC_ADDR_COUNT_LOW, wdata: 8'h77, wr: 1'h1, rd: 1'h0};
        @(posedge clock);
        fire <= 1'h0;
        bus <= '0;
        rchk("write wins", STC_ADDR_COUNT_LOW, 8'h77);
        wr(STC_ADDR_CONTROL, 8'h80);
        wr(STC_ADDR_COUNT_HIGH, 8'hAB);
        wr(STC_ADDR_COUNT_LOW, 8'hCD);
        rchk("wide low", STC_ADDR_COUNT_LOW, 8'hCD);
        rchk("wide high", STC_ADDR_COUNT_HIGH, 8'hAB);
        wr(STC_ADDR_COUNT_HIGH, 8'h55);
        rchk("wide low", STC_ADDR_COUNT_LOW, 8'hCD);
        rchk("live high", STC_ADDR_COUNT_HIGH, 8'hAB);
        wr(STC_ADDR_CONTROL, 8'h00);
        wr(STC_ADDR_COUNT_LOW, 8'h00);
        wr(STC_ADDR_COUNT_HIGH, 8'h00);
        wr(STC_ADDR_CONTROL, 8'h03);
        burst();
        wr(STC_ADDR_CONTROL, 8'h07);
        burst();
        wr(STC_ADDR_CONTROL, 8'h00);
        rchk("edges", STC_ADDR_COUNT_LOW, 8'h10);
        cmp("pin oe", 8'h03, {6'h00, pin_oe});
        wr(STC_ADDR_CONTROL, 8'h0F);
        use_osc <= 1'h1;
        repeat (20) @(posedge clock);
        cmp("osc run", 8'h01, {7'h00, osc_run});
        cmp("pin oe", 8'h00, {6'h00, pin_oe});
        cmp("pin read", 8'h00, {6'h00, pin_read});
        sleep_mode <= 1'h1;
        burst();
        sleep_mode <= 1'h0;
        wr(STC_ADDR_CONTROL, 8'h00);
        rchk("osc edges", STC_ADDR_COUNT_LOW, 8'h18);
        cmp("osc off", 8'h00, {7'h00, osc_run});
        cmp("pin read", 8'h03, {6'h00, pin_read});
        complete_run();
    end
endmodule
